/* File: logic/lsrs_exec.sv */
// Operation
// [RULE1] literal load puts immediate in accumulator, flags kept
// [RULE2] option load copies accumulator, flags kept
// [RULE3] return loads literal into accumulator and stack head into pc
// [RULE4] return takes two cycles, next fetch dropped
// [RULE5] sleep clears watchdog and its prescaler
// [RULE6] sleep sets timeout_n, clears powerdown_n, wake kept
// [RULE7] sleep halts execution and stops oscillator
// [RULE8] rotate left through carry, only carry changes
// [RULE9] rotate right through carry, only carry changes
// [RULE10] subtract accumulator from file, update C, DC, Z
// [RULE11] destination bit picks accumulator or file
// [RULE12] file operand is five-bit address field
// [RULE13] other instructions finish in one cycle
`timescale 1ns/1ps
`include "lsrs_map.svh"
module lsrs_exec
  import lsrs_pkg::*;
#(
  parameter int PC_W = 9
)(
  // clock and reset
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_N,
  input  wire logic                 CE,
  // instruction stream
  input  wire logic [`LSRS_IW-1:0]  INSTR,
  input  wire logic                 INSTR_VALID,
  // file register port
  output logic      [4:0]           FILE_RADDR,
  input  wire logic [7:0]           FILE_RDATA,
  output logic                      FILE_WE,
  output logic      [4:0]           FILE_WADDR,
  output logic      [7:0]           FILE_WDATA,
  // program counter
  input  wire logic [PC_W-1:0]      STACK_HEAD,
  output logic                      PC_LOAD,
  output logic      [PC_W-1:0]      PC_VALUE,
  // core state
  output logic      [7:0]           ACC,
  output logic      [7:0]           OPTION_REG,
  output logic                      CARRY,
  output logic                      HALF_CARRY,
  output logic                      ZERO,
  output logic                      TIMEOUT_FLAG_N,
  output logic                      POWERDOWN_FLAG_N,
  output logic                      PIN_CHANGE_WAKE_FLAG,
  // watchdog and sleep
  output logic                      WDT_CLEAR,
  output logic                      PRESCALER_CLEAR,
  output logic                      SLEEP,
  output logic                      OSC_STOP,
  input  wire logic                 WAKE_PIN,
  // apb slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR
);

////////////////////////////////////////////////////////////////////////////
  lsrs_state_t     state, next_state;
  lsrs_op_t        op;
  logic [7:0]      acc, next_acc;
  logic [7:0]      option_reg, next_option_reg;
  logic            carry, next_carry;
  logic            half_carry, next_half_carry;
  logic            zero, next_zero;
  logic            timeout_n, next_timeout_n;
  logic            powerdown_n, next_powerdown_n;
  logic            wake_flag, next_wake_flag;
  logic            file_we, next_file_we;
  logic [4:0]      file_waddr, next_file_waddr;
  logic [7:0]      file_wdata, next_file_wdata;
  logic            pc_load, next_pc_load;
  logic [PC_W-1:0] pc_value, next_pc_value;
  logic            wdt_clr, next_wdt_clr;
  logic            go;
  logic            dst_file;
  logic [7:0]      lit;
  logic [7:0]      result;
  logic [8:0]      diff;
  logic [4:0]      diff_lo;
  logic            wake_s1, wake_s2, wake_s3;
  logic            wake_rise;
  logic            sw_wake, sw_wclr;
  logic [31:0]     prdata, next_prdata;
  logic            perr, next_perr;
  logic            addr_ok;

////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb
  begin
    op = LSRS_NONE;
    if ((INSTR & `LSRS_MSK_LIT) == `LSRS_ENC_LDLIT)
      op = LSRS_LDLIT;
    else if ((INSTR & `LSRS_MSK_LIT) == `LSRS_ENC_RETL)
      op = LSRS_RETL;
    else if ((INSTR & `LSRS_MSK_FD) == `LSRS_ENC_RLC)
      op = LSRS_RLC;
    else if ((INSTR & `LSRS_MSK_FD) == `LSRS_ENC_RRC)
      op = LSRS_RRC;
    else if ((INSTR & `LSRS_MSK_FD) == `LSRS_ENC_SUB)
      op = LSRS_SUB;
    else if (INSTR == `LSRS_ENC_OPT)
      op = LSRS_OPT;
    else if (INSTR == `LSRS_ENC_SLP)
      op = LSRS_SLP;
  end

  assign go         = CE && INSTR_VALID && (state == LSRS_RUN);
  assign lit        = INSTR[`LSRS_LIT_HI:0];
  assign dst_file   = INSTR[`LSRS_DST_BIT];
  assign FILE_RADDR = INSTR[`LSRS_FADR_HI:0]; // RULE12
  // carry means no borrow, as usual for subtract on this core
  assign diff       = {1'b0, FILE_RDATA} - {1'b0, acc}; // RULE10
  assign diff_lo    = {1'b0, FILE_RDATA[3:0]} - {1'b0, acc[3:0]};

////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser; the second and third stages feed the rising-edge detect
  assign wake_rise = wake_s2 && !wake_s3;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
    end
    else if (CE)
    begin
      wake_s1 <= WAKE_PIN;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // execution next state
  always_comb
  begin
    next_state       = state; // RULE13
    next_acc         = acc;
    next_option_reg  = option_reg;
    next_carry       = carry;
    next_half_carry  = half_carry;
    next_zero        = zero;
    next_timeout_n   = timeout_n;
    next_powerdown_n = powerdown_n;
    next_wake_flag   = wake_flag;
    next_file_we     = 1'b0;
    next_file_waddr  = file_waddr;
    next_file_wdata  = file_wdata;
    next_pc_load     = 1'b0;
    next_pc_value    = pc_value;
    next_wdt_clr     = 1'b0;
    result           = 8'h00;
    if (sw_wclr)
      next_wake_flag = 1'b0;
    unique case (state)
      LSRS_RUN:
      begin
        if (INSTR_VALID)
        begin
          unique case (op)
            LSRS_LDLIT: next_acc = lit; // RULE1
            LSRS_OPT:   next_option_reg = acc; // RULE2
            LSRS_RETL:
            begin
              next_acc      = lit; // RULE3
              next_pc_load  = 1'b1;
              next_pc_value = STACK_HEAD;
              next_state    = LSRS_DISCARD; // RULE4
            end
            LSRS_SLP:
            begin
              next_wdt_clr     = 1'b1; // RULE5
              next_timeout_n   = 1'b1; // RULE6
              next_powerdown_n = 1'b0; // RULE6
              next_state       = LSRS_SLEEP; // RULE7
            end
            LSRS_RLC:
            begin
              result     = {FILE_RDATA[6:0], carry}; // RULE8
              next_carry = FILE_RDATA[7];
            end
            LSRS_RRC:
            begin
              result     = {carry, FILE_RDATA[7:1]}; // RULE9
              next_carry = FILE_RDATA[0];
            end
            LSRS_SUB:
            begin
              result          = diff[7:0]; // RULE10
              next_carry      = !diff[8];
              next_half_carry = !diff_lo[4];
              next_zero       = (diff[7:0] == 8'h00);
            end
            LSRS_NONE: ;
          endcase
          if (op == LSRS_RLC || op == LSRS_RRC || op == LSRS_SUB)
          begin
            if (dst_file) // RULE11
            begin
              next_file_we    = 1'b1;
              next_file_waddr = FILE_RADDR; // RULE12
              next_file_wdata = result;
            end
            else
              next_acc = result;
          end
        end
      end
      // the fetched word after a return is consumed and thrown away
      LSRS_DISCARD:
        if (INSTR_VALID)
          next_state = LSRS_RUN; // RULE4
      LSRS_SLEEP:
      begin
        if (wake_rise)
          next_wake_flag = 1'b1;
        if (wake_rise || sw_wake)
          next_state = LSRS_RUN;
      end
      // the spare state code falls back to run rather than locking up
      default:
        next_state = LSRS_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state       <= LSRS_RUN;
      acc         <= `LSRS_ACC_RST;
      option_reg  <= `LSRS_OPT_RST;
      carry       <= 1'b0;
      half_carry  <= 1'b0;
      zero        <= 1'b0;
      timeout_n   <= 1'b1;
      powerdown_n <= 1'b1;
      wake_flag   <= 1'b0;
      file_we     <= 1'b0;
      file_waddr  <= 5'h00;
      file_wdata  <= 8'h00;
      pc_load     <= 1'b0;
      pc_value    <= '0;
      wdt_clr     <= 1'b0;
    end
    else if (CE)
    begin
      state       <= next_state;
      acc         <= next_acc;
      option_reg  <= next_option_reg;
      carry       <= next_carry;
      half_carry  <= next_half_carry;
      zero        <= next_zero;
      timeout_n   <= next_timeout_n;
      powerdown_n <= next_powerdown_n;
      wake_flag   <= next_wake_flag;
      file_we     <= next_file_we;
      file_waddr  <= next_file_waddr;
      file_wdata  <= next_file_wdata;
      pc_load     <= next_pc_load;
      pc_value    <= next_pc_value;
      wdt_clr     <= next_wdt_clr;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, read data captured in the setup cycle
  assign addr_ok = (PADDR == `LSRS_ADR_ACC) || (PADDR == `LSRS_ADR_OPT) ||
                   (PADDR == `LSRS_ADR_STAT) || (PADDR == `LSRS_ADR_CTRL);
  assign sw_wclr = PSEL && PENABLE && PWRITE && !perr &&
                   (PADDR == `LSRS_ADR_CTRL) && PWDATA[`LSRS_CT_WCLR];
  assign sw_wake = PSEL && PENABLE && PWRITE && !perr &&
                   (PADDR == `LSRS_ADR_CTRL) && PWDATA[`LSRS_CT_WAKE];

  always_comb
  begin
    next_prdata = prdata;
    next_perr   = perr;
    if (PSEL && !PENABLE)
    begin
      next_perr   = !addr_ok;
      next_prdata = 32'h0000_0000;
      if (!PWRITE)
      begin
        if (PADDR == `LSRS_ADR_ACC)
          next_prdata[7:0] = acc;
        else if (PADDR == `LSRS_ADR_OPT)
          next_prdata[7:0] = option_reg;
        else if (PADDR == `LSRS_ADR_STAT)
        begin
          next_prdata[`LSRS_ST_C]     = carry;
          next_prdata[`LSRS_ST_DC]    = half_carry;
          next_prdata[`LSRS_ST_Z]     = zero;
          next_prdata[`LSRS_ST_PD_N]  = powerdown_n;
          next_prdata[`LSRS_ST_TO_N]  = timeout_n;
          next_prdata[`LSRS_ST_WAKE]  = wake_flag;
          next_prdata[`LSRS_ST_SLEEP] = (state == LSRS_SLEEP);
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prdata <= 32'h0000_0000;
      perr   <= 1'b0;
    end
    else if (CE)
    begin
      prdata <= next_prdata;
      perr   <= next_perr;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // outputs; a frozen clock enable also stalls the bus
  assign PRDATA               = prdata;
  assign PREADY               = CE;
  assign PSLVERR              = PSEL && PENABLE && perr;
  assign FILE_WE              = file_we;
  assign FILE_WADDR           = file_waddr;
  assign FILE_WDATA           = file_wdata;
  assign PC_LOAD              = pc_load;
  assign PC_VALUE             = pc_value;
  assign ACC                  = acc;
  assign OPTION_REG           = option_reg;
  assign CARRY                = carry;
  assign HALF_CARRY           = half_carry;
  assign ZERO                 = zero;
  assign TIMEOUT_FLAG_N       = timeout_n;
  assign POWERDOWN_FLAG_N     = powerdown_n;
  assign PIN_CHANGE_WAKE_FLAG = wake_flag;
  assign WDT_CLEAR            = wdt_clr;
  assign PRESCALER_CLEAR      = wdt_clr; // RULE5
  assign SLEEP                = (state == LSRS_SLEEP);
  assign OSC_STOP             = (state == LSRS_SLEEP); // RULE7

////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_ldlit;
    go && op == LSRS_LDLIT |=> acc == $past(lit) && $stable(carry) &&
      $stable(zero) && $stable(half_carry);
  endproperty
  a_ldlit: assert property (p_ldlit) else $error("literal load wrong"); // RULE1

  property p_opt;
    go && op == LSRS_OPT |=> option_reg == $past(acc) && $stable(carry);
  endproperty
  a_opt: assert property (p_opt) else $error("option load wrong"); // RULE2

  property p_retl;
    go && op == LSRS_RETL |=> PC_LOAD && PC_VALUE == $past(STACK_HEAD) &&
      acc == $past(lit) && $stable(zero);
  endproperty
  a_retl: assert property (p_retl) else $error("return wrong"); // RULE3

  sequence s_ret;
    go && op == LSRS_RETL ##1 state == LSRS_DISCARD;
  endsequence
  sequence s_drop;
    CE && INSTR_VALID ##1 state == LSRS_RUN && !FILE_WE && !PC_LOAD;
  endsequence
  property p_drop;
    s_ret ##0 (CE && INSTR_VALID) |-> s_drop ##0 $stable(acc);
  endproperty
  a_drop: assert property (p_drop) else $error("fetch not dropped"); // RULE4

  property p_wdt;
    go && op == LSRS_SLP |=> WDT_CLEAR && PRESCALER_CLEAR;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not cleared"); // RULE5

  property p_slp_flags;
    go && op == LSRS_SLP |=> TIMEOUT_FLAG_N && !POWERDOWN_FLAG_N;
  endproperty
  a_slp_flags: assert property (p_slp_flags) else $error("sleep flags"); // RULE6

  property p_halt;
    SLEEP && CE && !wake_rise && !sw_wake |=> SLEEP && OSC_STOP && !FILE_WE;
  endproperty
  a_halt: assert property (p_halt) else $error("sleep not held"); // RULE7

  property p_rlc;
    go && op == LSRS_RLC |=> carry == $past(FILE_RDATA[7]) &&
      (FILE_WE ? FILE_WDATA : acc) == $past({FILE_RDATA[6:0], carry});
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong"); // RULE8

  property p_rrc;
    go && op == LSRS_RRC |=> carry == $past(FILE_RDATA[0]) &&
      (FILE_WE ? FILE_WDATA : acc) == $past({carry, FILE_RDATA[7:1]});
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong"); // RULE9

  property p_sub;
    go && op == LSRS_SUB |=> zero == ($past(FILE_RDATA) == $past(acc)) &&
      half_carry == ($past(FILE_RDATA[3:0]) >= $past(acc[3:0])) &&
      carry == ($past(FILE_RDATA) >= $past(acc));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract flags wrong"); // RULE10

  property p_dst;
    go && (op == LSRS_SUB || op == LSRS_RLC || op == LSRS_RRC) |=>
      FILE_WE == $past(dst_file);
  endproperty
  a_dst: assert property (p_dst) else $error("destination wrong"); // RULE11

  property p_faddr;
    go && op == LSRS_SUB && dst_file |=> FILE_WADDR == $past(INSTR[4:0]);
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address wrong"); // RULE12

  property p_single;
    go && op != LSRS_RETL && op != LSRS_SLP |=> state == LSRS_RUN;
  endproperty
  a_single: assert property (p_single) else $error("not one cycle"); // RULE13

endmodule // lsrs_exec

/* File: logic/lsrs_map.svh */
`ifndef LSRS_MAP_SVH
`define LSRS_MAP_SVH
// instruction word layout
`define LSRS_IW         12
`define LSRS_MSK_LIT    12'hf00
`define LSRS_MSK_FD     12'hfc0
`define LSRS_ENC_LDLIT  12'hc00
`define LSRS_ENC_RETL   12'h800
`define LSRS_ENC_RLC    12'h340
`define LSRS_ENC_RRC    12'h300
`define LSRS_ENC_SUB    12'h080
`define LSRS_ENC_OPT    12'h002
`define LSRS_ENC_SLP    12'h003
`define LSRS_LIT_HI     7
`define LSRS_FADR_HI    4
`define LSRS_DST_BIT    5
// apb byte addresses
`define LSRS_ADR_ACC    8'h00
`define LSRS_ADR_OPT    8'h04
`define LSRS_ADR_STAT   8'h08
`define LSRS_ADR_CTRL   8'h0c
// status word bit positions
`define LSRS_ST_C       0
`define LSRS_ST_DC      1
`define LSRS_ST_Z       2
`define LSRS_ST_PD_N    3
`define LSRS_ST_TO_N    4
`define LSRS_ST_WAKE    5
`define LSRS_ST_SLEEP   6
// control word bit positions
`define LSRS_CT_WCLR    0
`define LSRS_CT_WAKE    1
// reset values
`define LSRS_ACC_RST    8'h00
`define LSRS_OPT_RST    8'hff
`endif

/* File: logic/lsrs_pkg.sv */
package lsrs_pkg;
  typedef enum logic [1:0] {LSRS_RUN, LSRS_DISCARD, LSRS_SLEEP} lsrs_state_t;
  typedef enum logic [2:0] {LSRS_NONE, LSRS_LDLIT, LSRS_OPT, LSRS_RETL,
                            LSRS_SLP, LSRS_RLC, LSRS_RRC, LSRS_SUB} lsrs_op_t;
endpackage

/* File: bench/lsrs_exec_tb.sv */
`timescale 1ns/1ps
`include "lsrs_map.svh"
module lsrs_exec_tb
  import lsrs_pkg::*;
;
  logic        REF_CLK;
  logic        RST_N;
  logic        CE;
  logic [11:0] INSTR;
  logic        INSTR_VALID;
  logic [4:0]  FILE_RADDR;
  logic [7:0]  FILE_RDATA;
  logic        FILE_WE;
  logic [4:0]  FILE_WADDR;
  logic [7:0]  FILE_WDATA;
  logic [8:0]  STACK_HEAD;
  logic        PC_LOAD;
  logic [8:0]  PC_VALUE;
  logic [7:0]  ACC;
  logic [7:0]  OPTION_REG;
  logic        CARRY;
  logic        HALF_CARRY;
  logic        ZERO;
  logic        TIMEOUT_FLAG_N;
  logic        POWERDOWN_FLAG_N;
  logic        PIN_CHANGE_WAKE_FLAG;
  logic        WDT_CLEAR;
  logic        PRESCALER_CLEAR;
  logic        SLEEP;
  logic        OSC_STOP;
  logic        WAKE_PIN;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  int          n_errors;
  int          n_tests;
  int          cycles;
  logic [31:0] rd;
  logic        er;

  lsrs_exec #(.PC_W(9)) dut (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .INSTR(INSTR),
    .INSTR_VALID(INSTR_VALID), .FILE_RADDR(FILE_RADDR),
    .FILE_RDATA(FILE_RDATA), .FILE_WE(FILE_WE), .FILE_WADDR(FILE_WADDR),
    .FILE_WDATA(FILE_WDATA), .STACK_HEAD(STACK_HEAD), .PC_LOAD(PC_LOAD),
    .PC_VALUE(PC_VALUE), .ACC(ACC), .OPTION_REG(OPTION_REG),
    .CARRY(CARRY), .HALF_CARRY(HALF_CARRY), .ZERO(ZERO),
    .TIMEOUT_FLAG_N(TIMEOUT_FLAG_N), .POWERDOWN_FLAG_N(POWERDOWN_FLAG_N),
    .PIN_CHANGE_WAKE_FLAG(PIN_CHANGE_WAKE_FLAG), .WDT_CLEAR(WDT_CLEAR),
    .PRESCALER_CLEAR(PRESCALER_CLEAR), .SLEEP(SLEEP), .OSC_STOP(OSC_STOP),
    .WAKE_PIN(WAKE_PIN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR)
  );

  ////////////////////////////////////////////////////////////////////////////
  always #2 REF_CLK = ~REF_CLK;

  // whole run is under a hundred cycles; a hang ends here
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one instruction, then an idle cycle; effects checked after the edge
  task automatic issue(input logic [11:0] i, input logic [7:0] fd);
    @(posedge REF_CLK);
    INSTR       <= i;
    FILE_RDATA  <= fd;
    INSTR_VALID <= 1'b1;
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b0;
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do
      @(posedge REF_CLK);
    while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // wake is synchronised first, so allow a short bounded wait
  task automatic wait_awake();
    for (int k = 0; k < 20 && SLEEP !== 1'b0; k++)
      @(posedge REF_CLK);
    #1;
    chk(SLEEP, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    REF_CLK = 0; RST_N = 0; CE = 1; INSTR = 0; INSTR_VALID = 0;
    FILE_RDATA = 0; STACK_HEAD = 0; WAKE_PIN = 0; PSEL = 0; PENABLE = 0;
    PWRITE = 0; PADDR = 0; PWDATA = 0; n_errors = 0; n_tests = 0;
    cycles = 0;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    #1;
    chk(ACC, 0);
    chk(OPTION_REG, 8'hff);
    chk({CARRY, HALF_CARRY, ZERO, PIN_CHANGE_WAKE_FLAG, SLEEP}, 0);
    chk({TIMEOUT_FLAG_N, POWERDOWN_FLAG_N}, 2'h3);
    // subtract into accumulator, low nibble borrows
    issue(`LSRS_ENC_LDLIT | 12'h001, 8'h00);
    chk(ACC, 8'h01);
    issue(`LSRS_ENC_SUB | 12'h003, 8'h10);
    chk(FILE_RADDR, 5'h03);
    chk(ACC, 8'h0f);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h4);
    chk(FILE_WE, 0);
    // equal operands written back to top file address
    issue(`LSRS_ENC_SUB | 12'h03f, 8'h0f);
    chk({FILE_WE, FILE_WADDR, FILE_WDATA}, {1'b1, 5'h1f, 8'h00});
    chk(ACC, 8'h0f);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h7);
    // the write strobe is a one-cycle pulse; look one edge later
    @(posedge REF_CLK);
    #1;
    chk(FILE_WE, 0);
    apb(1'b0, `LSRS_ADR_STAT, 0);
    chk(rd, 32'h1f);
    apb(1'b0, `LSRS_ADR_ACC, 0);
    chk(rd, 32'h0f);
    // full borrow
    issue(`LSRS_ENC_LDLIT | 12'h020, 8'h00);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h7);
    issue(`LSRS_ENC_SUB | 12'h003, 8'h10);
    chk(ACC, 8'hf0);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h2);
    // rotates: carry in and out, other flags kept
    issue(`LSRS_ENC_RLC | 12'h025, 8'h81);
    chk({FILE_WE, FILE_WADDR, FILE_WDATA}, {1'b1, 5'h05, 8'h02});
    chk({CARRY, HALF_CARRY, ZERO}, 3'h6);
    chk(ACC, 8'hf0);
    issue(`LSRS_ENC_RRC | 12'h007, 8'h02);
    chk(ACC, 8'h81);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h2);
    chk(FILE_WE, 0);
    issue(`LSRS_ENC_OPT, 8'h00);
    chk(OPTION_REG, 8'h81);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h2);
    issue(`LSRS_ENC_LDLIT | 12'h0ff, 8'h00);
    chk(ACC, 8'hff);
    chk({CARRY, HALF_CARRY, ZERO}, 3'h2);
    // register access, read-only write and unmapped place
    apb(1'b0, `LSRS_ADR_OPT, 0);
    chk(rd, 32'h81);
    apb(1'b1, `LSRS_ADR_ACC, 32'h55);
    chk(ACC, 8'hff);
    apb(1'b0, `LSRS_ADR_CTRL, 0);
    chk({er, rd}, 33'h0);
    apb(1'b0, 8'h10, 0);
    chk({er, rd}, {1'b1, 32'h0});
    // return with the next instruction already presented
    STACK_HEAD <= 9'h1c3;
    @(posedge REF_CLK);
    INSTR       <= `LSRS_ENC_RETL | 12'h0a5;
    INSTR_VALID <= 1'b1;
    @(posedge REF_CLK);
    INSTR <= `LSRS_ENC_LDLIT | 12'h0a7;
    #1;
    chk({PC_LOAD, PC_VALUE, ACC}, {1'b1, 9'h1c3, 8'ha5});
    chk({CARRY, HALF_CARRY, ZERO}, 3'h2);
    @(posedge REF_CLK);
    INSTR_VALID <= 1'b0;
    #1;
    chk({PC_LOAD, ACC}, {1'b0, 8'ha5});
    issue(`LSRS_ENC_LDLIT | 12'h033, 8'h00);
    chk(ACC, 8'h33);
    // first sleep, wake flag still clear
    issue(`LSRS_ENC_SLP, 8'h00);
    chk({WDT_CLEAR, PRESCALER_CLEAR}, 2'h3);
    chk({TIMEOUT_FLAG_N, POWERDOWN_FLAG_N}, 2'h2);
    chk(PIN_CHANGE_WAKE_FLAG, 0);
    chk({SLEEP, OSC_STOP}, 2'h3);
    issue(`LSRS_ENC_LDLIT | 12'h011, 8'h00);
    chk(ACC, 8'h33);
    chk({WDT_CLEAR, PRESCALER_CLEAR}, 2'h0);
    @(posedge REF_CLK);
    WAKE_PIN <= 1'b1;
    wait_awake();
    chk(PIN_CHANGE_WAKE_FLAG, 1);
    @(posedge REF_CLK);
    WAKE_PIN <= 1'b0;
    // second sleep, wake flag set beforehand must survive
    issue(`LSRS_ENC_SLP, 8'h00);
    chk(PIN_CHANGE_WAKE_FLAG, 1);
    chk({TIMEOUT_FLAG_N, POWERDOWN_FLAG_N}, 2'h2);
    apb(1'b0, `LSRS_ADR_STAT, 0);
    chk(rd, 32'h72);
    apb(1'b1, `LSRS_ADR_CTRL, 32'h3);
    wait_awake();
    chk(PIN_CHANGE_WAKE_FLAG, 0);
    issue(`LSRS_ENC_LDLIT | 12'h044, 8'h00);
    chk(ACC, 8'h44);
    results();
  end
endmodule // lsrs_exec_tb
